// file: src/loop_event_status.sv
// Purpose: Sticky event status bytes for the timing loops, with masks and irq.
// Assumes: Loop status levels and event pulses are synchronous to clk_i.
// Notes:   Set wins over a same-cycle write-one-to-clear.
// Functional notes
// - First analog loop unlock sets analog bit 3
// - First analog loop lock sets analog bit 2
// - First analog calibration done sets bit 1
// - First analog calibration start sets bit 0
// - Distribution synced sets bit 4; 7:5 zero
// - Second loop clamp inactive sets lock bit 7
// - Second loop clamp active sets lock bit 6
// - Slew limiter stops sets lock bit 5
// - Slew limiter starts sets lock bit 4
// - Frequency lock detector edges set bits 3/2
// - Phase lock detector edges set bits 1/0
//
// The Wishbone register port is this design's own decision.
module loop_event_status (
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    input  wire logic                               wb_cyc_i,
    input  wire logic                               wb_stb_i,
    input  wire logic                               wb_we_i,
    input  wire logic [irq_status_pkg::ADDR_W+1:0]  wb_adr_i,
    input  wire logic [3:0]                         wb_sel_i,
    input  wire logic [irq_status_pkg::DATA_W-1:0]  wb_dat_i,
    output logic      [irq_status_pkg::DATA_W-1:0]  wb_dat_o,
    output logic                                    wb_ack_o,
    output logic                                    irq_o,
    input  wire logic                               first_analog_loop_locked_i,
    input  wire logic                               first_analog_loop_cal_busy_i,
    input  wire logic                               ch0_dist_synced_i,
    input  wire logic                               second_loop_freq_clamped_i,
    input  wire logic                               second_loop_slew_limiting_i,
    input  wire logic                               frequency_lock_detector_i,
    input  wire logic                               phase_lock_detector_i,
    input  wire logic [7:0]                         ch1_state_evt_i,
    input  wire logic [7:0]                         ch1_fast_acquire_evt_i,
    input  wire logic [7:0]                         ch1_profile_evt_i,
    input  wire logic                               second_analog_loop_locked_i,
    input  wire logic                               second_analog_loop_cal_busy_i,
    input  wire logic                               ch1_dist_synced_i
);
    import irq_status_pkg::*;

    localparam int N = NUM_EVT_REGS;

    // Byte numbering of the clear word and the masks assumes six bytes
    if (N != 6) begin : g_bad_count
        $error("Six event bytes expected");
    end

    typedef logic [7:0] byte_t;

    byte_t  evt_q   [N];
    byte_t  mask_q  [N];
    byte_t  set_d   [N];
    logic   [6:0] prev_q;
    logic   req;
    logic   [ADDR_W-1:0] idx;

    // Rising and falling edges of a status level
    function automatic logic rose(input logic now, input logic was);
        return now & ~was;
    endfunction : rose

    function automatic logic fell(input logic now, input logic was);
        return ~now & was;
    endfunction : fell

    function automatic byte_t valid_bits(input int k);
        case (k)
            0, 5:    return VALID_ANALOG;
            1:       return VALID_LOCK;
            2:       return VALID_STATE;
            3:       return VALID_FACQ;
            4:       return VALID_PROFILE;
            default: return 8'h00;
        endcase
    endfunction : valid_bits

    // Previous levels, kept to find transitions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 7'h00;
        end else begin
            prev_q <= {second_analog_loop_cal_busy_i, second_analog_loop_locked_i,
                       phase_lock_detector_i, frequency_lock_detector_i,
                       second_loop_slew_limiting_i, second_loop_freq_clamped_i,
                       first_analog_loop_locked_i};
        end
    end

    // Separate history for the first loop's calibration level and both distribution sync levels
    logic cal0_prev_q;
    logic dist0_prev_q;
    logic dist1_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal0_prev_q  <= 1'b0;
            dist0_prev_q <= 1'b0;
            dist1_prev_q <= 1'b0;
        end else begin
            cal0_prev_q  <= first_analog_loop_cal_busy_i;
            dist0_prev_q <= ch0_dist_synced_i;
            dist1_prev_q <= ch1_dist_synced_i;
        end
    end

    always_comb begin
        for (int k = 0; k < N; k++) begin
            set_d[k] = 8'h00;
        end
        set_d[0][AN_UNLOCKED]  = fell(first_analog_loop_locked_i, prev_q[0]);
        set_d[0][AN_LOCKED]    = rose(first_analog_loop_locked_i, prev_q[0]);
        set_d[0][AN_CAL_DONE]  = fell(first_analog_loop_cal_busy_i, cal0_prev_q);
        set_d[0][AN_CAL_START] = rose(first_analog_loop_cal_busy_i, cal0_prev_q);
        set_d[0][AN_DIST_SYNC] = rose(ch0_dist_synced_i, dist0_prev_q);
        set_d[1][LK_CLAMP_OFF] = fell(second_loop_freq_clamped_i, prev_q[1]);
        set_d[1][LK_CLAMP_ON]  = rose(second_loop_freq_clamped_i, prev_q[1]);
        set_d[1][LK_SLEW_OFF]  = fell(second_loop_slew_limiting_i, prev_q[2]);
        set_d[1][LK_SLEW_ON]   = rose(second_loop_slew_limiting_i, prev_q[2]);
        set_d[1][LK_FR_UNLOCKED] = fell(frequency_lock_detector_i, prev_q[3]);
        set_d[1][LK_FR_LOCKED]   = rose(frequency_lock_detector_i, prev_q[3]);
        set_d[1][LK_PH_UNLOCKED] = fell(phase_lock_detector_i, prev_q[4]);
        set_d[1][LK_PH_LOCKED]   = rose(phase_lock_detector_i, prev_q[4]);
        // Pulsed sources; reserved lanes forced low
        set_d[2] = ch1_state_evt_i & VALID_STATE;
        set_d[3] = ch1_fast_acquire_evt_i & VALID_FACQ;
        set_d[4] = ch1_profile_evt_i & VALID_PROFILE;
        set_d[5][AN_UNLOCKED]  = fell(second_analog_loop_locked_i, prev_q[5]);
        set_d[5][AN_LOCKED]    = rose(second_analog_loop_locked_i, prev_q[5]);
        set_d[5][AN_CAL_DONE]  = fell(second_analog_loop_cal_busy_i, prev_q[6]);
        set_d[5][AN_CAL_START] = rose(second_analog_loop_cal_busy_i, prev_q[6]);
        set_d[5][AN_DIST_SYNC] = rose(ch1_dist_synced_i, dist1_prev_q);
    end

    // Bus decode: one cycle ack, dropped the cycle after
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign idx = wb_adr_i[ADDR_W+1:2];

    logic clr_wr;
    logic mask_wr;

    assign clr_wr  = req & wb_we_i & wb_sel_i[0] & (idx == IDX_CLEAR);
    assign mask_wr = req & wb_we_i & wb_sel_i[0] & (idx >= IDX_MASK) & (idx <= IDX_MASK_LAST);

    // Clear word: byte 0 picks the event byte, byte 1 holds ones to clear.
    // Keeps the status bytes themselves read-only as documented.
    logic [7:0] clr_sel;
    logic [7:0] clr_bits;

    assign clr_sel  = wb_dat_i[7:0];
    assign clr_bits = wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00;

    // Sticky bits: set wins over a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < N; k++) begin
                evt_q[k] <= EVT_RESET;
            end
        end else begin
            for (int k = 0; k < N; k++) begin
                if (clr_wr && clr_sel == 8'(k)) begin
                    evt_q[k] <= ((evt_q[k] & ~clr_bits) | set_d[k]) & valid_bits(k);
                end else begin
                    evt_q[k] <= (evt_q[k] | set_d[k]) & valid_bits(k);
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < N; k++) begin
                mask_q[k] <= MASK_RESET;
            end
        end else if (mask_wr) begin
            for (int k = 0; k < N; k++) begin
                if (idx == IDX_MASK + 16'(k)) begin
                    mask_q[k] <= wb_dat_i[7:0] & valid_bits(k);
                end
            end
        end
    end

    // Mask bit high enables the matching status bit onto irq_o
    always_comb begin
        irq_o = 1'b0;
        for (int k = 0; k < N; k++) begin
            irq_o = irq_o | (|(evt_q[k] & mask_q[k]));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= UNMAPPED_READ;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= UNMAPPED_READ;
            for (int k = 0; k < N; k++) begin
                if (idx == IDX_CH0_ANALOG + 16'(k)) begin
                    wb_dat_o <= {24'h000000, evt_q[k]};
                end
                if (idx == IDX_MASK + 16'(k)) begin
                    wb_dat_o <= {24'h000000, mask_q[k]};
                end
            end
        end
    end
endmodule : loop_event_status

// file: inc/irq_status_pkg.sv
// Purpose: Constants for the loop event status block.
// Assumes: Classic Wishbone, 32-bit data, byte addresses.
// Notes:   Word index is the printed offset; byte address is four times it.
package irq_status_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 32;
    localparam int          NUM_EVT_REGS    = 6;
    // Printed offsets as word indices
    localparam logic [15:0] IDX_CH0_ANALOG  = 16'h3014;
    localparam logic [15:0] IDX_CH1_LOCK    = 16'h3015;
    localparam logic [15:0] IDX_CH1_STATE   = 16'h3016;
    localparam logic [15:0] IDX_CH1_FACQ    = 16'h3017;
    localparam logic [15:0] IDX_CH1_PROFILE = 16'h3018;
    localparam logic [15:0] IDX_CH1_ANALOG  = 16'h3019;
    localparam logic [15:0] IDX_CLEAR       = 16'h3020;
    localparam logic [15:0] IDX_MASK        = 16'h3021;
    localparam logic [15:0] IDX_MASK_LAST   = 16'h3026;
    localparam logic [7:0]  EVT_RESET       = 8'h00;
    localparam logic [7:0]  MASK_RESET      = 8'h00;
    // Bits that can hold events in each byte, index 0 = offset 0x3014
    localparam logic [7:0]  VALID_ANALOG    = 8'h1F;
    localparam logic [7:0]  VALID_LOCK      = 8'hFF;
    localparam logic [7:0]  VALID_STATE     = 8'hFD;
    localparam logic [7:0]  VALID_FACQ      = 8'h1C;
    localparam logic [7:0]  VALID_PROFILE   = 8'h3F;
    // Analog byte fields
    localparam int          AN_CAL_START    = 0;
    localparam int          AN_CAL_DONE     = 1;
    localparam int          AN_LOCKED       = 2;
    localparam int          AN_UNLOCKED     = 3;
    localparam int          AN_DIST_SYNC    = 4;
    // Lock byte fields
    localparam int          LK_PH_LOCKED    = 0;
    localparam int          LK_PH_UNLOCKED  = 1;
    localparam int          LK_FR_LOCKED    = 2;
    localparam int          LK_FR_UNLOCKED  = 3;
    localparam int          LK_SLEW_ON      = 4;
    localparam int          LK_SLEW_OFF     = 5;
    localparam int          LK_CLAMP_ON     = 6;
    localparam int          LK_CLAMP_OFF    = 7;
    localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;
endpackage : irq_status_pkg

// file: dv/loop_event_status_assertions.sv
// Purpose: Port-level checks for loop_event_status.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Status bytes are only visible through reads, so checks hang on them.
module loop_event_status_checker (
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    input  wire logic                              wb_cyc_i,
    input  wire logic                              wb_stb_i,
    input  wire logic                              wb_we_i,
    input  wire logic [irq_status_pkg::ADDR_W+1:0] wb_adr_i,
    input  wire logic [irq_status_pkg::DATA_W-1:0] wb_dat_o,
    input  wire logic                              wb_ack_o,
    input  wire logic                              irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import irq_status_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_rd(a);
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == a;
    endsequence
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    property p_ack_resp; s_req |=> wb_ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle after request");
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_rst_quiet; disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && wb_dat_o == 32'h0; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
    property p_dat_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_upper: assert property (p_dat_upper) else $error("upper read data not zero");
    property p_an0_res; s_rd(18'h0C050) |=> wb_dat_o[7:5] == 3'h0; endproperty
    a_an0_res: assert property (p_an0_res) else $error("analog byte reserved bits set");
    property p_st_res; s_rd(18'h0C058) |=> !wb_dat_o[1]; endproperty
    a_st_res: assert property (p_st_res) else $error("state byte bit 1 set");
    property p_fa_res; s_rd(18'h0C05C) |=> wb_dat_o[7:5] == 3'h0 && wb_dat_o[1:0] == 2'h0; endproperty
    a_fa_res: assert property (p_fa_res) else $error("fast acquire reserved bits set");
    property p_pr_res; s_rd(18'h0C060) |=> wb_dat_o[7:6] == 2'h0; endproperty
    a_pr_res: assert property (p_pr_res) else $error("profile reserved bits set");
    property p_an1_res; s_rd(18'h0C064) |=> wb_dat_o[7:5] == 3'h0; endproperty
    a_an1_res: assert property (p_an1_res) else $error("ch1 analog reserved bits set");
    // Status only drops through a bus write
    property p_sticky; $fell(irq_o) |-> $past(wb_we_i) && $past(wb_stb_i); endproperty
    a_sticky: assert property (p_sticky) else $error("irq fell without a write");
endmodule : loop_event_status_checker

bind loop_event_status loop_event_status_checker loop_event_status_checker_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq_o);

// file: dv/loop_event_status_test.sv
// Purpose: Self-checking bench for loop_event_status.
// Assumes: Byte registers in bits 7:0; byte address is word index times four.
// Notes:   Events driven as levels or one-cycle pulses, then read back.
module pll_event_irq_status_test;
    timeunit 1ns;
    timeprecision 1ns;
    import irq_status_pkg::*;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [17:0] wb_adr_i;
    logic [3:0]  wb_sel_i, lock_lv;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [2:0]  an_lv [2];
    logic [7:0]  ev [3];
    int          err_count, num_checks;
    loop_event_status loop_event_status_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .first_analog_loop_locked_i(an_lv[0][1]), .first_analog_loop_cal_busy_i(an_lv[0][0]),
        .ch0_dist_synced_i(an_lv[0][2]), .second_loop_freq_clamped_i(lock_lv[3]),
        .second_loop_slew_limiting_i(lock_lv[2]), .frequency_lock_detector_i(lock_lv[1]),
        .phase_lock_detector_i(lock_lv[0]), .ch1_state_evt_i(ev[0]),
        .ch1_fast_acquire_evt_i(ev[1]), .ch1_profile_evt_i(ev[2]),
        .second_analog_loop_locked_i(an_lv[1][1]), .second_analog_loop_cal_busy_i(an_lv[1][0]),
        .ch1_dist_synced_i(an_lv[1][2]));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic [17:0] a, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : bus
    task automatic rd(input logic [17:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(q, exp);
    endtask : rd
    task automatic test_reset;
        for (int i = 0; i < 6; i++) begin
            rd(18'h0C050 + 18'(4 * i), 32'h0);
            rd(18'h0C084 + 18'(4 * i), 32'h0);
        end
        rd(18'h00100, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_analog(input int ch);
        logic [17:0] a;
        a = (ch != 0) ? 18'h0C064 : 18'h0C050;
        @(posedge clk_i) an_lv[ch][0] <= 1'b1;
        rd(a, 32'h01);
        @(posedge clk_i) an_lv[ch][0] <= 1'b0;
        rd(a, 32'h03);
        @(posedge clk_i) an_lv[ch][1] <= 1'b1;
        rd(a, 32'h07);
        @(posedge clk_i) an_lv[ch][1] <= 1'b0;
        rd(a, 32'h0F);
        @(posedge clk_i) an_lv[ch][2] <= 1'b1;
        rd(a, 32'h1F);
        $display("test_analog %0d done", ch);
    endtask : test_analog
    task automatic test_lock;
        logic [31:0] exp;
        exp = 32'h0;
        // Rise sets the even bit, fall the odd bit above it
        for (int k = 3; k >= 0; k--) begin
            @(posedge clk_i) lock_lv[k] <= 1'b1;
            exp[2*k] = 1'b1;
            rd(18'h0C054, exp);
            @(posedge clk_i) lock_lv[k] <= 1'b0;
            exp[2*k+1] = 1'b1;
            rd(18'h0C054, exp);
        end
        $display("test_lock done");
    endtask : test_lock
    task automatic test_pulses;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i) ev[i] <= 8'hFF;
            @(posedge clk_i) ev[i] <= 8'h00;
        end
        rd(18'h0C058, 32'hFD);
        rd(18'h0C05C, 32'h1C);
        rd(18'h0C060, 32'h3F);
        $display("test_pulses done");
    endtask : test_pulses
    task automatic test_irq;
        bus(18'h0C054, 1'b1, 32'h00);
        rd(18'h0C054, 32'hFF);
        chk({31'h0, irq_o}, 32'h0);
        bus(18'h0C088, 1'b1, 32'h81);
        rd(18'h0C088, 32'h81);
        chk({31'h0, irq_o}, 32'h1);
        bus(18'h0C080, 1'b1, 32'h0000_8101);
        rd(18'h0C054, 32'h7E);
        chk({31'h0, irq_o}, 32'h0);
        $display("test_irq done");
    endtask : test_irq
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_sel_i, wb_dat_i, lock_lv} = '0;
        an_lv = '{default: '0};
        ev = '{default: '0};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        test_analog(0);
        test_lock();
        test_pulses();
        test_analog(1);
        test_irq();
        print_verdict();
    end
    // Whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
endmodule : pll_event_irq_status_test
